//--- src/spi_stop_pkg.sv
// What this block does
// R1: Master bit clock period is (1 + divide value) times 2H; divide 0 runs as divide 1, giving 2 times 2H.
// R2: High phase is T/2 for odd or zero divide, else (div/2+1)*2H.
// R3: Low phase is T/2 for odd or zero divide, else (div/2)*2H.
// R4: As slave, generated clock runs at half CPU rate: source and divide 1.
// R5: Both sync polarities are 1; master drives an active-low slave-enable.
// R6: As slave, the active-low enables on both sync pins are inverted.
// R7: Master: transmit clock and sync are outputs; receive ones are inputs.
// R8: Slave: all clock and sync directions are inputs.
// R9: Slave-enable goes low before the enabling clock edge; transfer follows.
// R10: Receive data captured on falling edge, transmit launched on rising.
// R11: Enable low one period before first fall; held D after last rise.
// R12: First transmit bit appears one low-phase width after enable low.
// R13: Data pin released after the last bit, at the bit clock rising edge.
// R14: When idle, slave-enable stays high and the bit clock rests high.
`default_nettype none

package spi_stop_pkg;

  // Word and divider widths
  localparam int WORD_W_DEF = 8;
  localparam int DIV_W_DEF  = 8;

  // The CPU clock is clk_i itself, so 2H is one CPU period
  localparam int CPU_PERIOD_NS = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_PER_2H    = CPU_PERIOD_NS / CLK_PERIOD_NS;

  // Fixed slave clocking
  localparam int   SLAVE_DIV     = 1;
  localparam logic SLAVE_CLK_SRC = 1'h1;

  // Fixed SPI configuration
  localparam logic       SYNC_POL_SPI   = 1'h1;
  localparam logic       TX_CLK_POL_SPI = 1'h1;
  localparam logic [1:0] STOP_MODE_SPI  = 2'h3;

  // Pin directions and idle levels
  localparam logic DIR_OUT  = 1'h1;
  localparam logic DIR_IN   = 1'h0;
  localparam logic CLK_IDLE = 1'h1;
  localparam logic SE_IDLE  = 1'h1;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_LEAD  = 5'h02,
    ST_SHIFT = 5'h04,
    ST_TAIL  = 5'h08,
    ST_SLAVE = 5'h10
  } state_e;

endpackage

`default_nettype wire

//--- src/bitclk_if.sv
`default_nettype none

interface bitclk_if
  import spi_stop_pkg::*;
#(
  parameter int DIV_W = DIV_W_DEF
);
  logic             run;
  logic [DIV_W-1:0] div;
  logic             rise;
  logic             fall;

  modport gen  (input run, input div, output rise, output fall);
  modport user (output run, output div, input rise, input fall);
endinterface

`default_nettype wire

//--- src/bitclk_gen.sv
`default_nettype none

module bitclk_gen
  import spi_stop_pkg::*;
#(
  parameter int DIV_W = DIV_W_DEF
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Phase ticks to the shifter
  bitclk_if.gen    bc
);

  localparam int             LW     = DIV_W + 1;
  localparam logic [LW-1:0]  ONE    = LW'(1);
  localparam logic [LW-1:0]  PER_2H = LW'(CLK_PER_2H);

  logic          level_r;
  logic [LW-1:0] cnt_r;

  // Zero divide would need half-cycle phases; it runs as divide 1
  wire [LW-1:0] div_eff = (bc.div == '0) ? ONE : {1'b0, bc.div};
  wire          odd     = div_eff[0];
  wire [LW-1:0] half    = div_eff >> 1;
  wire [LW-1:0] lo_half = odd ? half + ONE : half;  // R3
  wire [LW-1:0] lo_len  = LW'(lo_half * PER_2H);   // R1
  wire [LW-1:0] hi_len  = LW'((half + ONE) * PER_2H); // R2
  wire [LW-1:0] cur_len = level_r ? hi_len : lo_len;
  wire          at_end  = (cnt_r == cur_len);

  // Ticks mark the edge at which the phase flips
  assign bc.rise = bc.run & ~level_r & at_end;
  assign bc.fall = bc.run & level_r & at_end;

  // Every start begins with a full low phase
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !bc.run) begin
      level_r <= 1'b0;
      cnt_r   <= ONE;
    end else if (at_end) begin
      level_r <= ~level_r;
      cnt_r   <= ONE;
    end else begin
      cnt_r <= cnt_r + ONE;
    end
  end

endmodule // bitclk_gen

`default_nettype wire

//--- src/spi_stop_port.sv
`default_nettype none

module spi_stop_port
  import spi_stop_pkg::*;
#(
  parameter int WORD_W = WORD_W_DEF,
  parameter int DIV_W  = DIV_W_DEF
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // Configuration
  input  wire logic              master_i,
  input  wire logic [DIV_W-1:0]  clock_divide_value_i,
  // Word side
  input  wire logic              load_i,
  input  wire logic [WORD_W-1:0] tx_data_i,
  output logic                   busy_o,
  output logic [WORD_W-1:0]      rx_data_o,
  output logic                   rx_valid_o,
  // Effective configuration
  output logic                   tx_clock_direction_o,
  output logic                   rx_clock_direction_o,
  output logic                   tx_sync_direction_o,
  output logic                   rx_sync_direction_o,
  output logic                   tx_sync_polarity_o,
  output logic                   rx_sync_polarity_o,
  output logic                   sample_clock_source_sel_o,
  output logic [1:0]             clock_stop_mode_field_o,
  output logic                   tx_clock_polarity_o,
  // Bit clock pin
  input  wire logic              serial_bit_clock_pin_i,
  output logic                   serial_bit_clock_pin_o,
  output logic                   serial_bit_clock_pin_oe_o,
  // Frame sync pins
  input  wire logic              tx_frame_sync_pin_i,
  output logic                   tx_frame_sync_pin_o,
  output logic                   tx_frame_sync_pin_oe_o,
  input  wire logic              rx_frame_sync_pin_i,
  // Data pins
  output logic                   tx_serial_data_pin_o,
  output logic                   tx_serial_data_pin_oe_o,
  input  wire logic              rx_serial_data_pin_i
);

  localparam int              CW    = $clog2(WORD_W + 1);
  localparam logic [CW-1:0]   LAST  = CW'(WORD_W - 1);
  localparam logic [CW-1:0]   DONE  = CW'(WORD_W);
  localparam logic [DIV_W-1:0] SDIV = DIV_W'(SLAVE_DIV);

  function automatic logic [WORD_W-1:0] shl(
    input logic [WORD_W-1:0] v
  );
    return {v[WORD_W-2:0], 1'b0};
  endfunction

  function automatic logic [WORD_W-1:0] cap(
    input logic [WORD_W-1:0] v,
    input logic              b
  );
    return {v[WORD_W-2:0], b};
  endfunction

  state_e            state_r;
  state_e            state_nxt;
  logic              mode_r;
  logic              mode_nxt;
  logic              run_r;
  logic              run_nxt;
  logic [WORD_W-1:0] tx_sh_r;
  logic [WORD_W-1:0] tx_sh_nxt;
  logic [WORD_W-1:0] rx_sh_r;
  logic [WORD_W-1:0] rx_sh_nxt;
  logic [CW-1:0]     cnt_r;
  logic [CW-1:0]     cnt_nxt;
  logic              clk_r;
  logic              clk_nxt;
  logic              se_r;
  logic              se_nxt;
  logic              dx_r;
  logic              dx_nxt;
  logic              dx_oe_r;
  logic              dx_oe_nxt;
  logic [WORD_W-1:0] rxd_r;
  logic [WORD_W-1:0] rxd_nxt;
  logic              rxv_r;
  logic              rxv_nxt;
  logic              sclk_r;

  bitclk_if #(.DIV_W(DIV_W)) bc ();

  bitclk_gen #(
    .DIV_W (DIV_W)
  ) u_gen (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .bc     (bc.gen)
  );

  // Slave samples at the generated half-rate clock
  assign bc.run = run_r;
  assign bc.div = mode_r ? clock_divide_value_i : SDIV; // R4

  // Enables arrive active low
  wire sel      = ~tx_frame_sync_pin_i;  // R6
  wire rsel     = ~rx_frame_sync_pin_i;  // R6
  wire strobe   = bc.rise;
  wire s_fall   = strobe & sclk_r & ~serial_bit_clock_pin_i;
  wire s_rise   = strobe & ~sclk_r & serial_bit_clock_pin_i;
  wire last_bit = (cnt_r == LAST);
  wire done     = (cnt_r == DONE);
  wire rx_bit   = rx_serial_data_pin_i;
  wire [WORD_W-1:0] rx_cap = cap(rx_sh_r, rx_bit);
  wire [CW-1:0]     cnt_inc = cnt_r + 1'b1;

  always_comb begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    run_nxt   = run_r;
    tx_sh_nxt = tx_sh_r;
    rx_sh_nxt = rx_sh_r;
    cnt_nxt   = cnt_r;
    clk_nxt   = clk_r;
    se_nxt    = se_r;
    dx_nxt    = dx_r;
    dx_oe_nxt = dx_oe_r;
    rxd_nxt   = rxd_r;
    rxv_nxt   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        mode_nxt  = master_i;
        clk_nxt   = CLK_IDLE;  // R14
        se_nxt    = SE_IDLE;   // R14
        dx_oe_nxt = 1'b0;
        run_nxt   = ~mode_r;
        // Wait for a stopped generator so each frame starts in phase
        if (mode_r) begin
          if (load_i && !run_r) begin
            tx_sh_nxt = tx_data_i;
            cnt_nxt   = '0;
            run_nxt   = 1'b1;
            se_nxt    = ~SE_IDLE;  // R5 R9
            state_nxt = ST_LEAD;
          end
        end else if (sel) begin
          dx_nxt    = tx_sh_r[WORD_W-1];
          tx_sh_nxt = shl(tx_sh_r);
          dx_oe_nxt = 1'b1;
          cnt_nxt   = '0;
          state_nxt = ST_SLAVE;
        end else if (load_i) begin
          tx_sh_nxt = tx_data_i;
        end
      end
      ST_LEAD: begin
        // Hidden first rise: clock pin stays high for a whole period
        if (bc.rise) begin
          dx_nxt    = tx_sh_r[WORD_W-1];  // R12
          tx_sh_nxt = shl(tx_sh_r);
          dx_oe_nxt = 1'b1;
          state_nxt = ST_SHIFT;  // R11
        end
      end
      ST_SHIFT: begin
        if (bc.fall) begin
          clk_nxt   = 1'b0;
          rx_sh_nxt = rx_cap;  // R10
          cnt_nxt   = cnt_inc;
          if (last_bit) begin
            rxd_nxt = rx_cap;
            rxv_nxt = 1'b1;
          end
        end else if (bc.rise) begin
          clk_nxt = 1'b1;
          if (done) begin
            dx_oe_nxt = 1'b0;  // R13
            state_nxt = ST_TAIL;
          end else begin
            dx_nxt    = tx_sh_r[WORD_W-1];  // R10
            tx_sh_nxt = shl(tx_sh_r);
          end
        end
      end
      ST_TAIL: begin
        // Enable held for one high phase after the last rise
        if (bc.fall) begin
          se_nxt    = SE_IDLE;  // R11
          run_nxt   = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      ST_SLAVE: begin
        if (!sel) begin
          dx_oe_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end else if (s_fall && rsel && !done) begin
          rx_sh_nxt = rx_cap;  // R10
          cnt_nxt   = cnt_inc;
          if (last_bit) begin
            rxd_nxt = rx_cap;
            rxv_nxt = 1'b1;
          end
        end else if (s_rise) begin
          if (done) begin
            dx_oe_nxt = 1'b0;  // R13
          end else begin
            dx_nxt    = tx_sh_r[WORD_W-1];  // R10
            tx_sh_nxt = shl(tx_sh_r);
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_r <= ST_IDLE;
      mode_r  <= 1'b0;
      run_r   <= 1'b0;
      tx_sh_r <= '0;
      rx_sh_r <= '0;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      run_r   <= run_nxt;
      tx_sh_r <= tx_sh_nxt;
      rx_sh_r <= rx_sh_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Slave clock seen at the sampling rate only
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sclk_r <= CLK_IDLE;
    end else if (strobe) begin
      sclk_r <= serial_bit_clock_pin_i;
    end
  end

  // Pins and word side
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      clk_r   <= CLK_IDLE;
      se_r    <= SE_IDLE;
      dx_r    <= 1'b0;
      dx_oe_r <= 1'b0;
      rxd_r   <= '0;
      rxv_r   <= 1'b0;
      busy_o  <= 1'b0;
    end else begin
      clk_r   <= clk_nxt;
      se_r    <= se_nxt;
      dx_r    <= dx_nxt;
      dx_oe_r <= dx_oe_nxt;
      rxd_r   <= rxd_nxt;
      rxv_r   <= rxv_nxt;
      busy_o  <= (state_nxt != ST_IDLE);
    end
  end

  // Directions follow the mode in use
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_clock_direction_o <= DIR_IN;
      rx_clock_direction_o <= DIR_IN;
      tx_sync_direction_o  <= DIR_IN;
      rx_sync_direction_o  <= DIR_IN;
    end else begin
      tx_clock_direction_o <= mode_nxt ? DIR_OUT : DIR_IN;  // R7 R8
      rx_clock_direction_o <= DIR_IN;  // R7 R8
      tx_sync_direction_o  <= mode_nxt ? DIR_OUT : DIR_IN;  // R7 R8
      rx_sync_direction_o  <= DIR_IN;  // R7 R8
    end
  end

  // Fixed clock-stop settings, shown for software visibility
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tx_sync_polarity_o        <= SYNC_POL_SPI;
      rx_sync_polarity_o        <= SYNC_POL_SPI;
      sample_clock_source_sel_o <= SLAVE_CLK_SRC;
      clock_stop_mode_field_o   <= STOP_MODE_SPI;
      tx_clock_polarity_o       <= TX_CLK_POL_SPI;
    end else begin
      tx_sync_polarity_o        <= SYNC_POL_SPI;  // R5
      rx_sync_polarity_o        <= SYNC_POL_SPI;  // R5
      sample_clock_source_sel_o <= SLAVE_CLK_SRC; // R4
      clock_stop_mode_field_o   <= STOP_MODE_SPI;
      tx_clock_polarity_o       <= TX_CLK_POL_SPI;
    end
  end

  // Pin and word outputs come straight from their flops
  assign serial_bit_clock_pin_o    = clk_r;
  assign serial_bit_clock_pin_oe_o = tx_clock_direction_o;  // R7 R8
  assign tx_frame_sync_pin_o       = se_r;                  // R5
  assign tx_frame_sync_pin_oe_o    = tx_sync_direction_o;   // R7 R8
  assign tx_serial_data_pin_o      = dx_r;
  assign tx_serial_data_pin_oe_o   = dx_oe_r;               // R13
  assign rx_data_o                 = rxd_r;
  assign rx_valid_o                = rxv_r;

endmodule // spi_stop_port

`default_nettype wire

//--- dv/spi_stop_props.sv
`default_nettype none

module spi_stop_props
  import spi_stop_pkg::*;
#(
  parameter int DIV_W = DIV_W_DEF
) (
  // Clock, reset, divide
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic [DIV_W-1:0] clock_divide_value_i,
  // Status and configuration
  input wire logic             busy_o,
  input wire logic             rx_valid_o,
  input wire logic             tx_clock_direction_o,
  input wire logic             rx_clock_direction_o,
  input wire logic             tx_sync_direction_o,
  input wire logic             rx_sync_direction_o,
  input wire logic             tx_sync_polarity_o,
  input wire logic             rx_sync_polarity_o,
  input wire logic             sample_clock_source_sel_o,
  input wire logic [1:0]       clock_stop_mode_field_o,
  input wire logic             tx_clock_polarity_o,
  // Pins
  input wire logic             serial_bit_clock_pin_o,
  input wire logic             serial_bit_clock_pin_oe_o,
  input wire logic             tx_frame_sync_pin_o,
  input wire logic             tx_frame_sync_pin_oe_o,
  input wire logic             tx_serial_data_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] hold_r;
  logic [1:0] prev_r;
  logic       first_r;
  wire  [1:0] pair = {serial_bit_clock_pin_o, tx_frame_sync_pin_o};
  wire  [9:0] div_w = 10'(clock_divide_value_i);
  // Divide 0 behaves as divide 1
  wire  [9:0] t_w = (div_w < 10'h002) ? 10'h002 : div_w + 10'h001;
  wire  [9:0] c_w = t_w >> 1;
  wire  [9:0] d_w = t_w - c_w;

  // Length of the current pin state, in cycles
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hold_r  <= 10'h000;
      prev_r  <= 2'h3;
      first_r <= 1'b0;
    end else begin
      prev_r  <= pair;
      hold_r  <= (pair != prev_r) ? 10'h001 : hold_r + 10'h001;
      first_r <= (prev_r[0] & ~pair[0]) | (first_r & ~(prev_r[1] & ~pair[1]));
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_IDLE: assert property (!busy_o |-> tx_frame_sync_pin_o
    && serial_bit_clock_pin_o) else $error("idle pins not high");
  AST_CFG: assert property (tx_sync_polarity_o && rx_sync_polarity_o
    && sample_clock_source_sel_o && tx_clock_polarity_o
    && clock_stop_mode_field_o == 2'h3) else $error("fixed config wrong");
  AST_DIR: assert property (!rx_clock_direction_o && !rx_sync_direction_o
    && tx_sync_direction_o == tx_clock_direction_o
    && serial_bit_clock_pin_oe_o == tx_clock_direction_o
    && tx_frame_sync_pin_oe_o == tx_clock_direction_o)
    else $error("pin directions wrong");
  AST_SE: assert property ($fell(tx_frame_sync_pin_o) |-> busy_o
    && tx_frame_sync_pin_oe_o) else $error("enable low outside master");
  AST_LOW: assert property ($rose(serial_bit_clock_pin_o) && busy_o
    |-> hold_r == c_w) else $error("low phase length wrong");
  AST_HIGH: assert property ($fell(serial_bit_clock_pin_o) && !first_r
    |-> hold_r == d_w) else $error("high phase length wrong");
  AST_LEAD: assert property ($fell(serial_bit_clock_pin_o) && first_r
    |-> hold_r == t_w) else $error("enable lead wrong");
  AST_FIRST: assert property ($rose(tx_serial_data_pin_oe_o)
    && tx_clock_direction_o |-> hold_r == c_w)
    else $error("first bit delay wrong");
  AST_TAIL: assert property ($rose(tx_frame_sync_pin_o)
    && tx_clock_direction_o |-> hold_r == d_w && serial_bit_clock_pin_o)
    else $error("enable tail wrong");
  AST_REL: assert property ($fell(tx_serial_data_pin_oe_o)
    && tx_clock_direction_o |-> $rose(serial_bit_clock_pin_o))
    else $error("data release off the rising edge");
  AST_VALID: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("receive strobe too long");

  cover property ($fell(tx_frame_sync_pin_o));
  cover property (rx_valid_o && !tx_clock_direction_o);
  cover property ($fell(serial_bit_clock_pin_o) && d_w != c_w);
endmodule // spi_stop_props

`default_nettype wire

//--- dv/spi_far_end.sv
`default_nettype none

module spi_far_end #(
  parameter int LAG = 7
) (
  input  wire logic       clk_i,
  input  wire logic       sck_i,
  input  wire logic       se_n_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] word_i,
  output var  logic       miso_o,
  output var  logic [7:0] got_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] sh_r;

  initial miso_o = 1'b0;
  // Deselected line keeps moving so a stale bit never looks valid
  always @(posedge clk_i) if (se_n_i) miso_o <= ~miso_o;
  always @(negedge se_n_i) begin
    sh_r = word_i;
    miso_o <= word_i[7];
  end
  always @(posedge sck_i) if (!se_n_i) begin
    sh_r = sh_r << 1;
    miso_o <= #(LAG) sh_r[7];
  end
  always @(negedge sck_i) if (!se_n_i) got_o <= {got_o[6:0], mosi_i};
endmodule // spi_far_end

`default_nettype wire

//--- dv/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_stop_pkg::*;

  logic       clk_i, nrst_i, master_i, load_i, busy_o, rx_valid_o;
  logic [7:0] clock_divide_value_i, tx_data_i, rx_data_o, sw, got;
  logic       tx_clock_direction_o, rx_clock_direction_o;
  logic       tx_sync_direction_o, rx_sync_direction_o;
  logic       tx_sync_polarity_o, rx_sync_polarity_o, tx_clock_polarity_o;
  logic       sample_clock_source_sel_o;
  logic [1:0] clock_stop_mode_field_o;
  logic       serial_bit_clock_pin_i, serial_bit_clock_pin_o;
  logic       serial_bit_clock_pin_oe_o, tx_frame_sync_pin_i;
  logic       tx_frame_sync_pin_o, tx_frame_sync_pin_oe_o;
  logic       rx_frame_sync_pin_i, tx_serial_data_pin_o;
  logic       tx_serial_data_pin_oe_o, rx_serial_data_pin_i;
  logic       miso, sck_s, fs_s, sdi;
  int         fail_count, compares;

  // Pin levels from whoever drives them
  assign serial_bit_clock_pin_i =
    serial_bit_clock_pin_oe_o ? serial_bit_clock_pin_o : sck_s;
  assign tx_frame_sync_pin_i =
    tx_frame_sync_pin_oe_o ? tx_frame_sync_pin_o : fs_s;
  assign rx_frame_sync_pin_i  = fs_s;
  assign rx_serial_data_pin_i = master_i ? miso : sdi;

  spi_stop_port DUT (
    .clk_i                     (clk_i),
    .nrst_i                    (nrst_i),
    .master_i                  (master_i),
    .clock_divide_value_i      (clock_divide_value_i),
    .load_i                    (load_i),
    .tx_data_i                 (tx_data_i),
    .busy_o                    (busy_o),
    .rx_data_o                 (rx_data_o),
    .rx_valid_o                (rx_valid_o),
    .tx_clock_direction_o      (tx_clock_direction_o),
    .rx_clock_direction_o      (rx_clock_direction_o),
    .tx_sync_direction_o       (tx_sync_direction_o),
    .rx_sync_direction_o       (rx_sync_direction_o),
    .tx_sync_polarity_o        (tx_sync_polarity_o),
    .rx_sync_polarity_o        (rx_sync_polarity_o),
    .sample_clock_source_sel_o (sample_clock_source_sel_o),
    .clock_stop_mode_field_o   (clock_stop_mode_field_o),
    .tx_clock_polarity_o       (tx_clock_polarity_o),
    .serial_bit_clock_pin_i    (serial_bit_clock_pin_i),
    .serial_bit_clock_pin_o    (serial_bit_clock_pin_o),
    .serial_bit_clock_pin_oe_o (serial_bit_clock_pin_oe_o),
    .tx_frame_sync_pin_i       (tx_frame_sync_pin_i),
    .tx_frame_sync_pin_o       (tx_frame_sync_pin_o),
    .tx_frame_sync_pin_oe_o    (tx_frame_sync_pin_oe_o),
    .rx_frame_sync_pin_i       (rx_frame_sync_pin_i),
    .tx_serial_data_pin_o      (tx_serial_data_pin_o),
    .tx_serial_data_pin_oe_o   (tx_serial_data_pin_oe_o),
    .rx_serial_data_pin_i      (rx_serial_data_pin_i)
  );

  spi_far_end FAR (
    .clk_i  (clk_i),
    .sck_i  (serial_bit_clock_pin_o),
    .se_n_i (tx_frame_sync_pin_o),
    .mosi_i (tx_serial_data_pin_o),
    .word_i (sw),
    .miso_o (miso),
    .got_o  (got)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(negedge clk_i) if (fs_s) sdi <= ~sdi;

  function automatic int tper(logic [7:0] d);
    return (d < 8'h02) ? 2 : int'(d) + 1;
  endfunction

  task automatic stop_test;
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic sframe(input logic [7:0] tw, sv);
    logic [7:0] q, s;
    tx_data_i = tw;
    load_i = 1'b1;
    s = sv;
    @(negedge clk_i);
    load_i = 1'b0;
    fs_s = 1'b0;
    @(negedge clk_i);
    sdi = s[7];
    repeat (4) @(negedge clk_i);
    for (int i = 7; i >= 0; i--) begin
      q[i] = tx_serial_data_pin_o;
      chk(tx_serial_data_pin_oe_o, 1);
      sck_s = 1'b0;
      repeat (4) @(negedge clk_i);
      sck_s = 1'b1;
      s = s << 1;
      sdi = s[7];
      repeat (4) @(negedge clk_i);
    end
    fs_s = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(tx_serial_data_pin_oe_o, 0);
    chk(q, tw);
    chk(rx_data_o, sv);
  endtask

  task automatic mframe(input logic [7:0] d, tw, s, input bit rf);
    int n, v;
    clock_divide_value_i = d;
    tx_data_i = tw;
    sw = s;
    load_i = 1'b1;
    @(negedge clk_i);
    load_i = 1'b0;
    n = 0;
    v = 0;
    // Busy rose at the taking edge; count from the first busy cycle
    while (busy_o === 1'b1 && n < 3000) begin
      n++;
      v += int'(rx_valid_o === 1'b1);
      // Load in mid-frame must be ignored
      load_i = rf && n == 3;
      if (load_i) tx_data_i = ~tw;
      @(negedge clk_i);
    end
    if (n == 3000) begin
      fail_count++;
      stop_test;
    end
    chk(n, 9 * tper(d));
    chk(v, 1);
    chk(got, tw);
    chk(rx_data_o, s);
    @(negedge clk_i);
    chk(busy_o, 0);
  endtask

  initial begin
    nrst_i = 1'b0;
    master_i = 1'b0;
    load_i = 1'b0;
    clock_divide_value_i = 8'h00;
    tx_data_i = 8'h00;
    sw = 8'h00;
    sck_s = 1'b1;
    fs_s = 1'b1;
    sdi = 1'b0;
    fail_count = 0;
    compares = 0;
    void'($urandom(32'h4311_6766));
    repeat (16) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    chk(serial_bit_clock_pin_oe_o, 0);
    sframe(8'($urandom), 8'($urandom));
    master_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk(serial_bit_clock_pin_oe_o, 1);
    for (int i = 0; i < 14; i++) begin
      mframe(i < 5 ? 8'(i) : 8'($urandom_range(9)),
             8'($urandom), 8'($urandom), i == 6);
    end
    stop_test;
  end
endmodule // tb

bind spi_stop_port spi_stop_props #(.DIV_W(DIV_W)) PRB (
  .clk_i                     (clk_i),
  .nrst_i                    (nrst_i),
  .clock_divide_value_i      (clock_divide_value_i),
  .busy_o                    (busy_o),
  .rx_valid_o                (rx_valid_o),
  .tx_clock_direction_o      (tx_clock_direction_o),
  .rx_clock_direction_o      (rx_clock_direction_o),
  .tx_sync_direction_o       (tx_sync_direction_o),
  .rx_sync_direction_o       (rx_sync_direction_o),
  .tx_sync_polarity_o        (tx_sync_polarity_o),
  .rx_sync_polarity_o        (rx_sync_polarity_o),
  .sample_clock_source_sel_o (sample_clock_source_sel_o),
  .clock_stop_mode_field_o   (clock_stop_mode_field_o),
  .tx_clock_polarity_o       (tx_clock_polarity_o),
  .serial_bit_clock_pin_o    (serial_bit_clock_pin_o),
  .serial_bit_clock_pin_oe_o (serial_bit_clock_pin_oe_o),
  .tx_frame_sync_pin_o       (tx_frame_sync_pin_o),
  .tx_frame_sync_pin_oe_o    (tx_frame_sync_pin_oe_o),
  .tx_serial_data_pin_oe_o   (tx_serial_data_pin_oe_o)
);

`default_nettype wire
